/* hot_plug_and_upgrade_control_tb_top.sv */
module hot_plug_and_upgrade_control_tb_top
   import hpu_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int ST = 10;
   localparam int WT = 10;
   logic i_clk, i_rst, i_send, i_bcast, i_first, i_last, i_pec_ok, i_fw_set;
   logic i_shutdown_fault, i_enable, i_erase_ok, i_prog_ok, i_validate_ok;
   logic [7:0] i_byte, i_voltage_select_pin, i_fw_setpoint, o_setpoint;
   logic [6:0] i_strap_addr, o_bus_addr;
   logic [15:0] i_fan_speed [NUM_FANS];
   logic [NUM_INFO-1:0] i_info_alarm, o_info_alarm;
   logic o_present, o_addr_valid, o_output_on, o_fan_warn, o_unlocked;
   logic o_in_boot, o_fault_indicator, o_ready, o_busy;
   int n_errors, checks;
   hpu_if bus_if();
   hpu_device #(.SETTLE_CYC(ST)) hpu_device_inst(.i_clk, .i_rst, .bus(bus_if),
      .i_strap_addr, .i_voltage_select_pin, .i_fw_setpoint, .i_fw_set,
      .i_fan_speed, .i_info_alarm, .i_shutdown_fault, .i_enable, .i_erase_ok,
      .i_prog_ok, .i_validate_ok, .o_present, .o_bus_addr, .o_addr_valid,
      .o_setpoint, .o_output_on, .o_fan_warn, .o_info_alarm, .o_unlocked,
      .o_in_boot, .o_fault_indicator);
   hpu_ctrl #(.WAIT_CYC(WT)) hpu_ctrl_inst(.i_clk, .i_rst, .bus(bus_if),
      .i_send, .i_bcast, .i_byte, .i_first, .i_last, .i_pec_ok, .o_ready,
      .o_busy);
   hpu_monitor #(.SETTLE_CYC(ST), .WAIT_CYC(WT)) hpu_monitor_inst(.i_clk,
      .i_rst, .present(bus_if.present), .addr_valid(bus_if.addr_valid),
      .bus_addr(bus_if.bus_addr), .byte_valid(bus_if.byte_valid),
      .byte_first(bus_if.byte_first), .byte_last(bus_if.byte_last),
      .byte_data(bus_if.byte_data), .broadcast(bus_if.broadcast),
      .pec_ok(bus_if.pec_ok));
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // bytes sent msb first, each held until the controller takes it
   task frame(input logic [47:0] b, input int n, input logic ok);
      int w;
      i_pec_ok = ok;
      for (int k = 0; k < n; k++) begin
         i_send = 1'b1;
         i_byte = b[8*(n-1-k)+:8];
         i_first = (k == 0);
         i_last = (k == n - 1);
         w = 0;
         do begin
            @(posedge i_clk);
            w++;
         end while (o_ready !== 1'b1 && w < 200);
         if (w >= 200) n_errors++;
         #1 i_send = 1'b0;
         tick(1);
      end
      tick(4);
   endtask
   task boot(input logic [7:0] d);
      frame({16'h0, CMD_BOOT, 8'h70, 8'h00, d}, 4, 1'b1);
   endtask
   task results;
      if (n_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #40000;
      n_errors++;
      results;
   end
   initial begin
      n_errors = 0;
      checks = 0;
      {i_send, i_bcast, i_first, i_last, i_pec_ok, i_fw_set} = 6'h0;
      {i_shutdown_fault, i_byte, i_info_alarm} = '0;
      {i_enable, i_erase_ok, i_prog_ok, i_validate_ok} = 4'hf;
      i_rst = 1'b1;
      i_strap_addr = 7'h2b;
      i_voltage_select_pin = 8'h12;
      i_fw_setpoint = 8'h30;
      i_fan_speed[0] = 16'h03e8;
      i_fan_speed[1] = 16'h03e8;
      tick(6);
      i_rst = 1'b0;
      tick(2);
      check(o_present, 1'b1);
      check(o_addr_valid, 1'b0);
      check(o_bus_addr, DEFAULT_ADDR);
      check(o_setpoint, i_voltage_select_pin);
      tick(ST + WT + 4);
      check(o_addr_valid, 1'b1);
      check(o_bus_addr, i_strap_addr);
      check(o_busy, 1'b0);
      i_fw_set = 1'b1;
      tick(1);
      i_fw_set = 1'b0;
      tick(2);
      check(o_setpoint, i_fw_setpoint);
      i_fan_speed[1] = 16'h04b0;
      tick(3);
      check(o_fan_warn, 1'b0);
      i_fan_speed[1] = 16'h04b1;
      tick(3);
      check(o_fan_warn, 1'b1);
      i_info_alarm = {NUM_INFO{1'b1}};
      tick(3);
      check(o_info_alarm, {NUM_INFO{1'b1}});
      check(o_output_on, 1'b1);
      boot(BOOT_ENTER);
      check(o_in_boot, 1'b0);
      frame({CMD_PASSWORD, PW_COUNT, 32'h55504758}, 6, 1'b1);
      check(o_unlocked, 1'b0);
      frame({CMD_PASSWORD, PW_COUNT, PW_WORD}, 6, 1'b0);
      check(o_unlocked, 1'b0);
      frame({CMD_PASSWORD, PW_COUNT, PW_WORD}, 6, 1'b1);
      check(o_unlocked, 1'b1);
      check(o_fault_indicator, 1'b0);
      boot(BOOT_ENTER);
      check(o_in_boot, 1'b1);
      check(o_output_on, 1'b0);
      i_erase_ok = 1'b0;
      boot(BOOT_ERASE);
      check(o_fault_indicator, 1'b1);
      tick(5);
      check(o_fault_indicator, 1'b1);
      i_erase_ok = 1'b1;
      i_validate_ok = 1'b0;
      boot(BOOT_ERASE);
      boot(BOOT_DONE);
      boot(BOOT_EXIT);
      check(o_in_boot, 1'b1);
      i_validate_ok = 1'b1;
      boot(BOOT_ERASE);
      boot(BOOT_DONE);
      boot(BOOT_EXIT);
      check(o_in_boot, 1'b0);
      check(o_fault_indicator, 1'b0);
      results;
   end
endmodule

/* hpu_ctrl.sv */
module hpu_ctrl
   import hpu_pkg::*;
#(
   parameter int unsigned WAIT_CYC = CTRL_WAIT_CYC
)(
   input wire logic i_clk,
   input wire logic i_rst,
   hpu_if.ctrl bus,
   input wire logic i_send,
   input wire logic i_bcast,
   input wire logic [7:0] i_byte,
   input wire logic i_first,
   input wire logic i_last,
   input wire logic i_pec_ok,
   output logic o_ready,
   output logic o_busy
);
   typedef struct packed {
      logic was_present;
      logic [31:0] wait_cnt;
      logic ready;
      logic bv, bf, bl, bc, pec;
      logic [7:0] data;
   } hpu_ctl_t;
   hpu_ctl_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.was_present = bus.present;
      if (bus.present && !s_q.was_present) begin
         s_d.ready = 1'b0;
         s_d.wait_cnt = '0;
      end else if (!s_q.ready && bus.present) begin
         if (s_q.wait_cnt == WAIT_CYC - 1) s_d.ready = 1'b1;
         else s_d.wait_cnt = s_q.wait_cnt + 32'h1;
      end
      s_d.bv = i_send && (s_q.ready || i_bcast);
      // frame marks only ride on a byte that is really sent
      s_d.bf = i_first && s_d.bv;
      s_d.bl = i_last && s_d.bv;
      s_d.bc = i_bcast;
      s_d.data = i_byte;
      s_d.pec = i_pec_ok;
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) s_q <= '0;
      else s_q <= s_d;
   end
   always_comb begin
      bus.byte_valid = s_q.bv;
      bus.byte_first = s_q.bf;
      bus.byte_last = s_q.bl;
      bus.byte_data = s_q.data;
      bus.broadcast = s_q.bc;
      bus.pec_ok = s_q.pec;
   end
   assign o_ready = s_q.ready;
   assign o_busy = !s_q.ready;
endmodule

/* hpu_device.sv */
// Behaviour
// - address settles one second after insertion
// - default address low three bits zero
// - controller holds addressed commands while settling
// - device drives presence signal
// - controller waits one second after reinsertion
// - output starts at voltage-select pin level
// - fan speed spread over 20% warns
// - information alarms never shut output
// - boot loader until validated upgrade, reset (code: reset loads HPU_APP, and BOOT_EXIT also leaves after BOOT_ENTER alone)
// - controller upgrades one processor at time
// - fault indicator shows upgrade state
// - wink 0.25/0.75 s, fast 0.25/0.25 s
// - boot loader turns output off
// - password command with UPGD unlocks
// - execute only after PEC validated
module hpu_device
   import hpu_pkg::*;
#(
   parameter int unsigned SETTLE_CYC = ADDR_SETTLE_CYC
)(
   input wire logic i_clk,
   input wire logic i_rst,
   hpu_if.device bus,
   input wire logic [6:0] i_strap_addr,
   input wire logic [7:0] i_voltage_select_pin,
   input wire logic [7:0] i_fw_setpoint,
   input wire logic i_fw_set,
   input wire logic [15:0] i_fan_speed [NUM_FANS],
   input wire logic [NUM_INFO-1:0] i_info_alarm,
   input wire logic i_shutdown_fault,
   input wire logic i_enable,
   input wire logic i_erase_ok,
   input wire logic i_prog_ok,
   input wire logic i_validate_ok,
   output logic o_present,
   output logic [6:0] o_bus_addr,
   output logic o_addr_valid,
   output logic [7:0] o_setpoint,
   output logic o_output_on,
   output logic o_fan_warn,
   output logic [NUM_INFO-1:0] o_info_alarm,
   output logic o_unlocked,
   output logic o_in_boot,
   output logic o_fault_indicator
);
   typedef struct packed {
      logic [31:0] settle;
      logic addr_ok;
      logic [6:0] addr;
      logic [7:0] setpoint;
      logic fan_warn;
      logic [NUM_INFO-1:0] info;
      logic out_on;
      logic unlocked;
      hpu_ustate_t ust;
      logic pending;
      logic [2:0] idx;
      logic [7:0] cmd;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [31:0] word;
      logic strap_done;
      logic present;
      logic fled;
      logic in_boot;
   } hpu_dev_t;
   hpu_dev_t s_q, s_d;
   hpu_led_t led_mode;
   logic led;
   logic fan_bad;
   logic [NUM_FANS-1:0] fan_over;
   logic [17:0] fmin;
   // spread check: max*100 > min*120
   // slowest fan is the reference, each fan is held against it
   always_comb begin
      fmin = 18'h3ffff;
      for (int i = 0; i < NUM_FANS; i++) begin
         if ({2'h0, i_fan_speed[i]} < fmin) begin
            fmin = {2'h0, i_fan_speed[i]};
         end
      end
   end
   genvar g;
   generate
      for (g = 0; g < NUM_FANS; g++) begin : g_fan
         assign fan_over[g] = (32'(i_fan_speed[g]) * 100) >
            (32'(fmin) * (100 + FAN_TOL_PCT));
      end
   endgenerate
   assign fan_bad = |fan_over;
   always_comb begin
      s_d = s_q;
      // settle timer, default address until done
      if (!s_q.addr_ok) begin
         if (s_q.settle == SETTLE_CYC - 1) begin
            s_d.addr_ok = 1'b1;
            s_d.addr = i_strap_addr;
         end else begin
            s_d.settle = s_q.settle + 32'h1;
         end
      end
      // hold pin level until firmware sets it
      if (i_fw_set) begin
         s_d.setpoint = i_fw_setpoint;
      end
      s_d.fan_warn = fan_bad;
      // warnings are only reported, they never gate the output
      s_d.info = i_info_alarm;
      s_d.out_on = i_enable && !i_shutdown_fault;
      // output forced off whenever the boot loader owns the part
      if (s_q.ust != HPU_APP) begin
         s_d.out_on = 1'b0;
      end
      if (s_q.ust == HPU_UPGRADING) begin
         if (!i_erase_ok || !i_prog_ok) begin
            s_d.ust = HPU_FAIL;
         end
      end
      // frame capture
      if (bus.byte_valid && s_q.addr_ok && !bus.broadcast) begin
         if (bus.byte_first) begin
            s_d.cmd = bus.byte_data;
            s_d.idx = 3'h1;
            s_d.pending = 1'b0;
         end else begin
            case (s_q.idx)
               3'h1: s_d.b1 = bus.byte_data;
               3'h2: s_d.b2 = bus.byte_data;
               default: s_d.word = {s_q.word[23:0], bus.byte_data};
            endcase
            s_d.idx = s_q.idx + 3'h1;
         end
         if (bus.byte_last) s_d.pending = 1'b1;
      end
      if (s_q.pending) begin
         s_d.pending = 1'b0;
         if (bus.pec_ok) begin
            if (s_q.cmd == CMD_PASSWORD && s_q.idx == PW_LEN &&
                s_q.b1 == PW_COUNT) begin
               // first letter in b2, the other three in the shift word
               s_d.unlocked = ({s_q.b2, s_q.word[23:0]} == PW_WORD);
            end else if (s_q.cmd == CMD_BOOT && s_q.unlocked &&
                         s_q.idx == BOOT_LEN) begin
               case (s_q.word[7:0])
                  BOOT_ENTER: s_d.ust = HPU_BOOT_GOOD;
                  BOOT_ERASE: s_d.ust = HPU_UPGRADING;
                  BOOT_DONE: s_d.ust = i_validate_ok ? HPU_BOOT_GOOD : HPU_FAIL;
                  BOOT_EXIT: if (s_q.ust == HPU_BOOT_GOOD) s_d.ust = HPU_APP;
                  default: s_d.ust = s_q.ust;
               endcase
            end
         end
      end
      // pin level taken once, unless firmware writes in that same cycle
      if (!s_q.strap_done) begin
         s_d.strap_done = 1'b1;
         if (!i_fw_set) begin
            s_d.setpoint = i_voltage_select_pin;
         end
      end
      s_d.present = 1'b1;
      // indicator registered so the pin comes straight from a flop
      s_d.fled = led;
      s_d.in_boot = (s_d.ust != HPU_APP);
   end
   always_comb begin
      case (s_q.ust)
         HPU_APP: led_mode = HPU_LED_OFF;
         HPU_BOOT_GOOD: led_mode = HPU_LED_WINK;
         HPU_UPGRADING: led_mode = HPU_LED_FAST;
         default: led_mode = HPU_LED_ON;
      endcase
   end
   hpu_led_pattern u_led (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_mode(led_mode),
      .o_led(led)
   );
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   // unsettled parts answer at the shared default address
   always_comb begin
      bus.present = s_q.present;
      bus.addr_valid = s_q.addr_ok;
      if (s_q.addr_ok) begin
         bus.bus_addr = s_q.addr;
      end else begin
         bus.bus_addr = {DEFAULT_ADDR[6:3], ADDR_LOW_ZERO};
      end
   end
   assign o_present = s_q.present;
   assign o_fault_indicator = s_q.fled;
   assign o_bus_addr = s_q.addr;
   assign o_addr_valid = s_q.addr_ok;
   assign o_setpoint = s_q.setpoint;
   assign o_output_on = s_q.out_on;
   assign o_fan_warn = s_q.fan_warn;
   assign o_info_alarm = s_q.info;
   assign o_unlocked = s_q.unlocked;
   assign o_in_boot = s_q.in_boot;
endmodule

/* hpu_if.sv */
interface hpu_if;
   import hpu_pkg::*;
   logic present;
   logic addr_valid;
   logic [6:0] bus_addr;
   logic byte_valid;
   logic byte_first;
   logic byte_last;
   logic [7:0] byte_data;
   logic broadcast;
   logic pec_ok;
   modport device (
      output present, addr_valid, bus_addr,
      input byte_valid, byte_first, byte_last, byte_data, broadcast, pec_ok
   );
   modport ctrl (
      input present, addr_valid, bus_addr,
      output byte_valid, byte_first, byte_last, byte_data, broadcast, pec_ok
   );
endinterface

/* hpu_led_pattern.sv */
module hpu_led_pattern
   import hpu_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire hpu_led_t i_mode,
   output logic o_led
);
   typedef struct packed {
      logic [31:0] cnt;
      logic led;
      hpu_led_t mode;
   } hpu_lp_t;
   hpu_lp_t s_q, s_d;
   logic [31:0] off_len;
   always_comb begin
      s_d = s_q;
      off_len = (i_mode == HPU_LED_WINK) ? WINK_OFF_CYC : BLINK_OFF_CYC;
      s_d.mode = i_mode;
      if (i_mode != s_q.mode) begin
         s_d.cnt = '0;
         s_d.led = (i_mode != HPU_LED_OFF);
      end else begin
         case (i_mode)
            HPU_LED_OFF: s_d.led = 1'b0;
            HPU_LED_ON: s_d.led = 1'b1;
            default: begin
               // on 0.25 s, off 0.75 s (wink) or 0.25 s (fast)
               if (s_q.led && s_q.cnt == LED_ON_CYC - 1) begin
                  s_d.led = 1'b0;
                  s_d.cnt = '0;
               end else if (!s_q.led && s_q.cnt == off_len - 1) begin
                  s_d.led = 1'b1;
                  s_d.cnt = '0;
               end else begin
                  s_d.cnt = s_q.cnt + 32'h1;
               end
            end
         endcase
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign o_led = s_q.led;
endmodule

/* hpu_monitor.sv */
module hpu_monitor
   import hpu_pkg::*;
#(
   parameter int SETTLE_CYC = 10,
   parameter int WAIT_CYC = 10
)(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic present,
   input wire logic addr_valid,
   input wire logic [6:0] bus_addr,
   input wire logic byte_valid,
   input wire logic byte_first,
   input wire logic byte_last,
   input wire logic [7:0] byte_data,
   input wire logic broadcast,
   input wire logic pec_ok
);
   // cycles since reset release, and since presence came up
   logic [15:0] cnt_q;
   logic [15:0] pcnt_q;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= 16'h0;
         pcnt_q <= 16'h0;
      end else begin
         if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h1;
         if (!present) pcnt_q <= 16'h0;
         else if (pcnt_q != 16'hffff) pcnt_q <= pcnt_q + 16'h1;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   chk_present_on: assert property (cnt_q > 16'h2 |-> present)
      else $error("presence not driven");
   chk_default_addr: assert property (!addr_valid |->
      bus_addr == DEFAULT_ADDR && bus_addr[2:0] == ADDR_LOW_ZERO)
      else $error("address not default before settle");
   chk_settle_early: assert property (cnt_q < SETTLE_CYC - 1 |-> !addr_valid)
      else $error("address valid too early");
   chk_settle_late: assert property (cnt_q > SETTLE_CYC + 2 |-> addr_valid)
      else $error("address valid too late");
   chk_addr_hold: assert property (addr_valid |=>
      addr_valid && $stable(bus_addr))
      else $error("settled address changed");
   chk_bcast_early: assert property (byte_valid && !broadcast |-> addr_valid)
      else $error("addressed byte during settle");
   chk_ctrl_wait: assert property (byte_valid && !broadcast |->
      pcnt_q >= WAIT_CYC - 1)
      else $error("addressed byte before wait");
   chk_frame_mark: assert property (byte_first || byte_last |-> byte_valid)
      else $error("frame mark without byte");
endmodule

/* hpu_pkg.sv */
package hpu_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned ADDR_SETTLE_MS = 1000;
   localparam int unsigned ADDR_SETTLE_CYC = ADDR_SETTLE_MS * (CLK_HZ / 1000);
   localparam int unsigned CTRL_WAIT_MS = 1000;
   localparam int unsigned CTRL_WAIT_CYC = CTRL_WAIT_MS * (CLK_HZ / 1000);
   localparam int unsigned LED_ON_MS = 250;
   localparam int unsigned LED_ON_CYC = LED_ON_MS * (CLK_HZ / 1000);
   localparam int unsigned WINK_OFF_MS = 750;
   localparam int unsigned WINK_OFF_CYC = WINK_OFF_MS * (CLK_HZ / 1000);
   localparam int unsigned BLINK_OFF_MS = 250;
   localparam int unsigned BLINK_OFF_CYC = BLINK_OFF_MS * (CLK_HZ / 1000);
   localparam int unsigned FAN_TOL_PCT = 20;
   localparam int unsigned NUM_FANS = 2;
   localparam int unsigned NUM_INFO = 9;
   localparam logic [6:0] DEFAULT_ADDR = 7'h00;
   localparam logic [2:0] ADDR_LOW_ZERO = 3'h0;
   localparam logic [7:0] CMD_PASSWORD = 8'he0;
   localparam logic [7:0] CMD_BOOT = 8'he6;
   localparam logic [7:0] PW_COUNT = 8'h04;
   localparam logic [31:0] PW_WORD = 32'h55504744;
   localparam logic [7:0] BOOT_ENTER = 8'h01;
   localparam logic [7:0] BOOT_ERASE = 8'h02;
   localparam logic [7:0] BOOT_DONE = 8'h03;
   localparam logic [7:0] BOOT_EXIT = 8'h04;
   localparam logic [2:0] PW_LEN = 3'h6;
   localparam logic [2:0] BOOT_LEN = 3'h4;
   typedef enum logic [1:0] {
      HPU_LED_OFF = 2'b00,
      HPU_LED_WINK = 2'b01,
      HPU_LED_FAST = 2'b10,
      HPU_LED_ON = 2'b11
   } hpu_led_t;
   typedef enum logic [1:0] {
      HPU_APP = 2'b00,
      HPU_BOOT_GOOD = 2'b01,
      HPU_UPGRADING = 2'b10,
      HPU_FAIL = 2'b11
   } hpu_ustate_t;
endpackage
